// >>> common/pcr_pkg.sv
// Package with register map, field layout and carrier types for the power and clock bank.
package pcr_pkg;

  localparam int unsigned PCR_ADDR_W = 7;
  localparam int unsigned PCR_DATA_W = 16;

  localparam logic [6:0] PCR_OFS_POWER = 7'h01;
  localparam logic [6:0] PCR_OFS_CLOCK = 7'h02;
  localparam logic [6:0] PCR_OFS_REF = 7'h03;

  localparam logic [15:0] PCR_RST_POWER = 16'h0000;
  localparam logic [15:0] PCR_RST_CLOCK = 16'h0000;
  localparam logic [15:0] PCR_RST_REF = 16'h0000;

  localparam int unsigned PCR_POW_CLK_FLAG_BIT = 11;
  localparam int unsigned PCR_POW_DIG1_FLAG_BIT = 10;
  localparam int unsigned PCR_POW_DIG2_FLAG_BIT = 9;
  localparam logic [15:0] PCR_POW_RO_MASK = 16'h0E00;

  localparam int unsigned PCR_CLK_RX_OFF_BIT = 5;
  localparam int unsigned PCR_CLK_SAVE_BIT = 4;
  localparam logic [15:0] PCR_CLK_INVERT_MASK = 16'h000F;

  localparam logic [5:0] PCR_TRIM_HIGHEST = 6'h20;
  localparam logic [5:0] PCR_TRIM_DEFAULT = 6'h00;
  localparam logic [5:0] PCR_TRIM_LOWEST = 6'h1F;

  typedef struct packed {
    logic [3:0] spare;
    logic clock_regulator_on_flag;
    logic digital1_regulator_on_flag;
    logic digital2_regulator_on_flag;
    logic clock_regulator_off;
    logic digital1_regulator_off;
    logic digital2_regulator_off;
    logic reference_resistor_off;
    logic bandgap_power_down;
    logic chan1_output_off;
    logic chan2_output_off;
    logic chan3_output_off;
    logic chan4_output_off;
  } pcr_power_t;

  typedef struct packed {
    logic [3:0] spare;
    logic chan1_clock_gate;
    logic chan2_clock_gate;
    logic chan3_clock_gate;
    logic chan4_clock_gate;
    logic core_logic_clock_gate;
    logic clock_sleep;
    logic clock_receiver_off;
    logic receiver_power_save;
    logic chan1_clock_invert;
    logic chan2_clock_invert;
    logic chan3_clock_invert;
    logic chan4_clock_invert;
  } pcr_clock_t;

  typedef struct packed {
    logic [9:0] spare;
    logic signed [5:0] bandgap_trim_code;
  } pcr_ref_t;

  typedef struct packed {
    logic clock_regulator_on;
    logic digital1_regulator_on;
    logic digital2_regulator_on;
  } pcr_status_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [15:0] wdata;
  } pcr_req_t;

endpackage : pcr_pkg

// >>> core/pcr_regs.sv
// Power, clock and reference control register bank in the serial-port domain.
`timescale 1ns/1ps
`default_nettype none

module pcr_regs (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic soft_reset_i,
  input wire pcr_pkg::pcr_req_t req_i,
  input wire pcr_pkg::pcr_status_t status_i,
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  output pcr_pkg::pcr_power_t power_o,
  output pcr_pkg::pcr_clock_t clock_o,
  output pcr_pkg::pcr_ref_t ref_o
);
  import pcr_pkg::*;

  // Register state with next values, and the decoded strobes.
  pcr_power_t power_r;
  pcr_power_t power_nxt;
  pcr_clock_t clock_r;
  pcr_clock_t clock_nxt;
  pcr_ref_t ref_r;
  pcr_ref_t ref_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic wr_power;
  logic wr_clock;
  logic wr_ref;
  logic rd_power;
  logic rd_clock;
  logic rd_ref;

  // True when the bus address selects the register at the given offset.
  function automatic logic hit(input logic [6:0] a, input logic [6:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Builds a power word from stored or written data and the live regulator flags.
  function automatic pcr_power_t power_word(input logic [15:0] w, input pcr_status_t s);
    pcr_power_t b;
    pcr_power_t p;
    b = pcr_power_t'(w & ~PCR_POW_RO_MASK);
    p.spare = b.spare;
    p.clock_regulator_on_flag = s.clock_regulator_on;
    p.digital1_regulator_on_flag = s.digital1_regulator_on;
    p.digital2_regulator_on_flag = s.digital2_regulator_on;
    p.clock_regulator_off = b.clock_regulator_off;
    p.digital1_regulator_off = b.digital1_regulator_off;
    p.digital2_regulator_off = b.digital2_regulator_off;
    p.reference_resistor_off = b.reference_resistor_off;
    p.bandgap_power_down = b.bandgap_power_down;
    p.chan1_output_off = b.chan1_output_off;
    p.chan2_output_off = b.chan2_output_off;
    p.chan3_output_off = b.chan3_output_off;
    p.chan4_output_off = b.chan4_output_off;
    power_word = p;
  endfunction : power_word

  // Splits a bus word into the clock register fields.
  function automatic pcr_clock_t clock_word(input logic [15:0] w);
    pcr_clock_t b;
    pcr_clock_t c;
    b = pcr_clock_t'(w);
    c.spare = b.spare;
    c.chan1_clock_gate = b.chan1_clock_gate;
    c.chan2_clock_gate = b.chan2_clock_gate;
    c.chan3_clock_gate = b.chan3_clock_gate;
    c.chan4_clock_gate = b.chan4_clock_gate;
    c.core_logic_clock_gate = b.core_logic_clock_gate;
    c.clock_sleep = b.clock_sleep;
    c.clock_receiver_off = b.clock_receiver_off;
    c.receiver_power_save = b.receiver_power_save;
    c.chan1_clock_invert = b.chan1_clock_invert;
    c.chan2_clock_invert = b.chan2_clock_invert;
    c.chan3_clock_invert = b.chan3_clock_invert;
    c.chan4_clock_invert = b.chan4_clock_invert;
    clock_word = c;
  endfunction : clock_word

  // Splits a bus word into the reference register fields.
  function automatic pcr_ref_t ref_word(input logic [15:0] w);
    pcr_ref_t b;
    pcr_ref_t r;
    b = pcr_ref_t'(w);
    r.spare = b.spare;
    r.bandgap_trim_code = b.bandgap_trim_code;
    ref_word = r;
  endfunction : ref_word

  // Address decode of the write and read strobes.
  // Unmapped addresses raise no strobe, so they store nothing and read zero.
  always_comb begin
    wr_power = 1'b0;
    wr_clock = 1'b0;
    wr_ref = 1'b0;
    rd_power = 1'b0;
    rd_clock = 1'b0;
    rd_ref = 1'b0;
    if (req_i.wr) begin
      wr_power = hit(req_i.addr, PCR_OFS_POWER);
      wr_clock = hit(req_i.addr, PCR_OFS_CLOCK);
      wr_ref = hit(req_i.addr, PCR_OFS_REF);
    end
    if (req_i.rd) begin
      rd_power = hit(req_i.addr, PCR_OFS_POWER);
      rd_clock = hit(req_i.addr, PCR_OFS_CLOCK);
      rd_ref = hit(req_i.addr, PCR_OFS_REF);
    end
  end

  // Power register: the flags follow the regulators on every edge, soft reset included.
  always_comb begin
    power_nxt = power_word(power_r, status_i);
    if (soft_reset_i) begin
      power_nxt = power_word(PCR_RST_POWER, status_i);
    end else if (wr_power) begin
      power_nxt = power_word(req_i.wdata, status_i);
    end
  end

  // Hardware reset clears the flags together with the writable fields.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      power_r <= pcr_power_t'(PCR_RST_POWER);
    end else begin
      power_r <= power_nxt;
    end
  end

  // Clock register: gates, receiver modes and inversions as written.
  // Inversion during power save is not blocked; software keeps the two apart.
  always_comb begin
    clock_nxt = clock_r;
    if (soft_reset_i) begin
      clock_nxt = clock_word(PCR_RST_CLOCK);
    end else if (wr_clock) begin
      clock_nxt = clock_word(req_i.wdata);
    end
  end

  // Clock register flops.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      clock_r <= pcr_clock_t'(PCR_RST_CLOCK);
    end else begin
      clock_r <= clock_nxt;
    end
  end

  // Reference register: signed trim code and stored reserved bits.
  always_comb begin
    ref_nxt = ref_r;
    if (soft_reset_i) begin
      ref_nxt = ref_word(PCR_RST_REF);
    end else if (wr_ref) begin
      ref_nxt = ref_word(req_i.wdata);
    end
  end

  // Reference register flops.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ref_r <= pcr_ref_t'(PCR_RST_REF);
    end else begin
      ref_r <= ref_nxt;
    end
  end

  // Read port: a read sees the value held before a write in the same cycle.
  always_comb begin
    rdata_nxt = 16'h0000;
    rvalid_nxt = req_i.rd;
    if (rd_power) begin
      rdata_nxt = power_r;
    end else if (rd_clock) begin
      rdata_nxt = clock_r;
    end else if (rd_ref) begin
      rdata_nxt = ref_r;
    end
  end

  // Read answer flops; the answer stands for one cycle.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // Every output is a plain copy of a register.
  assign power_o = power_r;
  assign clock_o = clock_r;
  assign ref_o = ref_r;
  assign rdata_o = rdata_r;
  assign rvalid_o = rvalid_r;

endmodule : pcr_regs

`default_nettype wire

// >>> verification/pcr_regs_properties.sv
// Assertion checker for the power and clock register bank.
`timescale 1ns/1ps
`default_nettype none
module pcr_regs_properties (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic soft_reset_i,
  input wire pcr_pkg::pcr_req_t req_i,
  input wire pcr_pkg::pcr_status_t status_i,
  input wire logic [15:0] rdata_o,
  input wire logic rvalid_o,
  input wire pcr_pkg::pcr_power_t power_o,
  input wire pcr_pkg::pcr_clock_t clock_o,
  input wire pcr_pkg::pcr_ref_t ref_o
);
  import pcr_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire logic ws = req_i.wr && !soft_reset_i;
  wire logic [6:0] a = req_i.addr;
  a_read_answer: assert property (req_i.rd |=> rvalid_o) else $error("no answer");
  a_quiet_bus: assert property (!req_i.rd |=> !rvalid_o) else $error("stray answer");
  sequence s_clock_read;
    req_i.rd && a == PCR_OFS_CLOCK;
  endsequence
  sequence s_power_read;
    req_i.rd && a == PCR_OFS_POWER;
  endsequence
  a_clock_read: assert property (s_clock_read |=> rdata_o == $past(clock_o))
    else $error("bad read");
  a_power_read: assert property (s_power_read |=> rdata_o == $past(power_o))
    else $error("bad power read");
  a_soft_power: assert property (soft_reset_i |=> {power_o[15:12], power_o[8:0]} == 13'h0000)
    else $error("soft power");
  a_flag_live: assert property (!soft_reset_i |=> power_o[11:9] == $past(status_i))
    else $error("stale flags");
  a_power_write: assert property (ws && a == PCR_OFS_POWER |=>
    {power_o[15:12], power_o[8:0]} == {$past(req_i.wdata[15:12]), $past(req_i.wdata[8:0])})
    else $error("power write");
  a_clock_write: assert property (ws && a == PCR_OFS_CLOCK |=> clock_o == $past(req_i.wdata))
    else $error("clock write");
  a_ref_write: assert property (ws && a == PCR_OFS_REF |=> ref_o == $past(req_i.wdata))
    else $error("ref write");
  a_soft_clear: assert property (soft_reset_i |=> clock_o == '0 && ref_o == '0)
    else $error("soft reset");
  a_hold_value: assert property (!req_i.wr |=> $stable(clock_o) || $past(soft_reset_i))
    else $error("value moved");
endmodule : pcr_regs_properties
bind pcr_regs pcr_regs_properties i_chk (
  .clk_sys_i(clk_sys_i),
  .rst_i(rst_i),
  .soft_reset_i(soft_reset_i),
  .req_i(req_i),
  .status_i(status_i),
  .rdata_o(rdata_o),
  .rvalid_o(rvalid_o),
  .power_o(power_o),
  .clock_o(clock_o),
  .ref_o(ref_o)
);
`default_nettype wire

// >>> verification/pcr_regs_tb_top.sv
// Self-checking bench for the power and clock register bank.
`timescale 1ns/1ps
`default_nettype none
module pcr_regs_tb_top;
  import pcr_pkg::*;
  logic clk_sys_i = 1'h0, rst_i = 1'h1, soft_reset_i = 1'h0, rvalid;
  pcr_req_t req = '0;
  pcr_status_t st;
  logic [15:0] rdata;
  logic seen_v;
  logic [15:0] seen_q;
  pcr_power_t pw;
  pcr_clock_t ck;
  pcr_ref_t rf;
  int miscompares = 0, n_tests = 0;
  pcr_regs i_dut (.clk_sys_i, .rst_i, .soft_reset_i, .req_i(req), .status_i(st),
    .rdata_o(rdata), .rvalid_o(rvalid), .power_o(pw), .clock_o(ck), .ref_o(rf));
  pcr_status_model i_reg (.power_i(pw), .status_o(st));
  initial forever #20 clk_sys_i = ~clk_sys_i;
  task automatic chk(input string n, input logic [15:0] s, e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [6:0] a, input logic [15:0] d);
    req = '{w, !w, a, d};
    @(negedge clk_sys_i);
    seen_v = rvalid;
    seen_q = rdata;
    req = '0;
    @(negedge clk_sys_i);
  endtask : acc
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    acc(1'h0, a, 16'h0000);
    chk("rvalid", {15'h0000, seen_v}, 16'h0001);
    chk("rdata", seen_q, e);
    chk("rvalid idle", {15'h0000, rvalid}, 16'h0000);
  endtask : rd
  task automatic t_power;
    @(negedge clk_sys_i);
    rd(PCR_OFS_POWER, 16'h0E00);
    acc(1'h1, PCR_OFS_POWER, 16'hFFFF);
    @(negedge clk_sys_i);
    rd(PCR_OFS_POWER, 16'hF1FF);
    chk("chan4", {15'h0000, pw.chan4_output_off}, 16'h0001);
  endtask : t_power
  task automatic t_clock;
    acc(1'h1, PCR_OFS_CLOCK, 16'hA5F0);
    acc(1'h1, PCR_OFS_REF, 16'h0020);
    chk("clock", ck, 16'hA5F0);
    chk("trim", {10'h000, rf.bandgap_trim_code}, 16'h0020);
    rd(PCR_OFS_CLOCK, 16'hA5F0);
    rd(PCR_OFS_REF, 16'h0020);
    acc(1'h1, PCR_OFS_CLOCK, 16'h000F);
    rd(PCR_OFS_CLOCK, 16'h000F);
    acc(1'h1, 7'h04, 16'hFFFF);
    rd(7'h04, 16'h0000);
    rd(PCR_OFS_CLOCK, 16'h000F);
  endtask : t_clock
  task automatic t_soft;
    acc(1'h1, PCR_OFS_REF, 16'hFFDF);
    rd(PCR_OFS_REF, 16'hFFDF);
    soft_reset_i = 1'h1;
    acc(1'h1, PCR_OFS_REF, 16'h001F);
    soft_reset_i = 1'h0;
    rd(PCR_OFS_REF, 16'h0000);
    rd(PCR_OFS_POWER, 16'h0E00);
    rd(PCR_OFS_CLOCK, 16'h0000);
  endtask : t_soft
  task automatic t_reset;
    acc(1'h1, PCR_OFS_CLOCK, 16'h5A0F);
    chk("clock", ck, 16'h5A0F);
    rst_i = 1'h1;
    @(negedge clk_sys_i);
    chk("power", pw, 16'h0000);
    chk("clock", ck, 16'h0000);
    chk("ref", rf, 16'h0000);
    rst_i = 1'h0;
    @(negedge clk_sys_i);
    rd(PCR_OFS_POWER, 16'h0E00);
    rd(PCR_OFS_CLOCK, 16'h0000);
  endtask : t_reset
  task automatic summarize;
    $display("Checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial begin
    repeat (2) @(negedge clk_sys_i);
    rst_i = 1'h0;
    t_power;
    t_clock;
    t_soft;
    t_reset;
    summarize;
  end
  initial begin
    #8000;
    miscompares++;
    summarize;
  end
endmodule : pcr_regs_tb_top
`default_nettype wire

// >>> verification/pcr_status_model.sv
// Regulator model that reports each regulator on while it is not switched off.
`timescale 1ns/1ps
`default_nettype none
module pcr_status_model (
  input wire pcr_pkg::pcr_power_t power_i,
  output var pcr_pkg::pcr_status_t status_o
);
  assign status_o = ~power_i[8:6];
endmodule : pcr_status_model
`default_nettype wire
